// ===== rcc_flag.sv
// Module: one sticky flag, hardware set wins over software write
`timescale 1ns/1ns
module rcc_flag
    import rcc_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_set,
    input wire logic i_wr,
    input wire logic i_wdata,
    output logic o_q
);
    logic next_q;
    assign next_q = i_set ? 1'b1 : (i_wr ? i_wdata : o_q);
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_q <= RST_VAL;
        end else begin
            o_q <= next_q;
        end
    end
endmodule : rcc_flag

// ===== rcc_pkg.sv
// Package: register map, field positions and reset values of the reset cause block
package rcc_pkg;
    localparam int unsigned RCC_AW = 4;
    localparam int unsigned RCC_DW = 16;
    // Register addresses
    localparam logic [3:0] RCC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] RCC_ADDR_IRQ_STAT = 4'h1;
    localparam logic [3:0] RCC_ADDR_IRQ_EN = 4'h2;
    localparam logic [3:0] RCC_ADDR_IRQ_CLR = 4'h3;
    // Field positions of reset_cause_and_control
    localparam int unsigned RCC_BIT_SBO = 13;
    localparam int unsigned RCC_BIT_FRS = 11;
    localparam int unsigned RCC_BIT_CMF = 9;
    localparam int unsigned RCC_BIT_MRS = 8;
    localparam int unsigned RCC_BIT_PIN = 7;
    localparam int unsigned RCC_BIT_SFT = 6;
    localparam int unsigned RCC_BIT_WDE = 5;
    localparam int unsigned RCC_BIT_BOF = 1;
    localparam int unsigned RCC_BIT_POF = 0;
    // Implemented bits of this block; 15, 14, 12, 10 and 4 to 2 read zero
    localparam logic [15:0] RCC_CTRL_MASK = 16'h2be3;
    // Power-on value: only the two lowest flags set
    localparam logic [15:0] RCC_CTRL_RST = 16'h0003;
    // Interrupt events: 0 pin reset, 1 soft reset, 2 config mismatch
    localparam int unsigned RCC_NEV = 3;
    localparam logic [2:0] RCC_EV_ZERO = 3'h0;
    localparam logic [15:0] RCC_ZERO16 = 16'h0000;
endpackage : rcc_pkg

// ===== rcc_regs.sv
// Module: reset cause and control register bank with event interrupts
//
// Summary of operation
// - Main regulator sleep select bit 8 drives output
// - Pin reset sets pin reset flag bit 7
// - Reset instruction sets soft reset flag 6
// - Soft watchdog enable bit 5 steers watchdog
// - Flags software writable; writes never cause reset
// - Fuse watchdog enable one forces watchdog on
// - Soft brownout enable ignored when fuse zero
// - Power-on clears all except two lowest flags
`timescale 1ns/1ns
module rcc_regs
    import rcc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [RCC_AW-1:0] i_addr,
    input wire logic [RCC_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [RCC_DW-1:0] o_rdata,
    input wire logic i_pin_reset_evt,
    input wire logic i_soft_reset_evt,
    input wire logic i_cfg_mismatch_evt,
    input wire logic i_fuse_watchdog_enable,
    input wire logic i_fuse_brownout_enable,
    output logic o_watchdog_on,
    output logic o_brownout_on,
    output logic o_main_regulator_sleep_active,
    output logic o_flash_regulator_sleep_active,
    output logic o_irq
);
    logic [RCC_DW-1:0] ctrl;
    logic [RCC_DW-1:0] hw_set;
    logic [RCC_NEV-1:0] irq_stat;
    logic [RCC_NEV-1:0] irq_en;
    logic [RCC_NEV-1:0] evt;
    logic [RCC_NEV-1:0] next_irq_stat;
    logic [RCC_DW-1:0] rd_mux;
    logic wr_ctrl;
    logic wr_en;
    logic wr_clr;
    logic next_watchdog;
    logic next_brownout;
    logic irq_any;
    logic [RCC_DW-1:0] next_rdata;

    assign wr_ctrl = i_wr && (i_addr == RCC_ADDR_CTRL);
    assign wr_en = i_wr && (i_addr == RCC_ADDR_IRQ_EN);
    assign wr_clr = i_wr && (i_addr == RCC_ADDR_IRQ_CLR);
    assign evt = {i_cfg_mismatch_evt, i_soft_reset_evt, i_pin_reset_evt};

    // Hardware set sources; writing ones only stores them, no reset output exists
    always_comb begin
        hw_set = RCC_ZERO16;
        hw_set[RCC_BIT_PIN] = i_pin_reset_evt;
        hw_set[RCC_BIT_SFT] = i_soft_reset_evt;
        hw_set[RCC_BIT_CMF] = i_cfg_mismatch_evt;
    end

    // One flop per implemented bit; unimplemented ones tie to zero
    genvar gi;
    generate
        for (gi = 0; gi < RCC_DW; gi++) begin : g_bit
            if (RCC_CTRL_MASK[gi]) begin : g_impl
                rcc_flag #(
                    .RST_VAL(RCC_CTRL_RST[gi])
                ) u_flag (
                    .i_clk_sys(i_clk_sys),
                    .i_rst(i_rst),
                    .i_set(hw_set[gi]),
                    .i_wr(wr_ctrl),
                    .i_wdata(i_wdata[gi]),
                    .o_q(ctrl[gi])
                );
            end else begin : g_none
                assign ctrl[gi] = 1'b0;
            end
        end
    endgenerate

    assign next_watchdog = i_fuse_watchdog_enable | ctrl[RCC_BIT_WDE];
    assign next_brownout = i_fuse_brownout_enable & ctrl[RCC_BIT_SBO];
    // Set wins over a clear written in the same cycle
    assign next_irq_stat = evt | (irq_stat & ~(wr_clr ? i_wdata[RCC_NEV-1:0] : RCC_EV_ZERO));
    assign irq_any = |(irq_stat & irq_en);
    assign next_rdata = i_rd ? rd_mux : RCC_ZERO16;

    always_comb begin
        rd_mux = RCC_ZERO16;
        if (i_addr == RCC_ADDR_CTRL) begin
            rd_mux = ctrl;
        end else if (i_addr == RCC_ADDR_IRQ_STAT) begin
            rd_mux[RCC_NEV-1:0] = irq_stat;
        end else if (i_addr == RCC_ADDR_IRQ_EN) begin
            rd_mux[RCC_NEV-1:0] = irq_en;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            irq_stat <= RCC_EV_ZERO;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            irq_en <= RCC_EV_ZERO;
        end else if (wr_en) begin
            irq_en <= i_wdata[RCC_NEV-1:0];
        end
    end

    // Interrupt pin follows the enabled status one cycle later
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_any;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= RCC_ZERO16;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_watchdog_on <= 1'b0;
            o_brownout_on <= 1'b0;
        end else begin
            o_watchdog_on <= next_watchdog;
            o_brownout_on <= next_brownout;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_main_regulator_sleep_active <= 1'b0;
            o_flash_regulator_sleep_active <= 1'b0;
        end else begin
            o_main_regulator_sleep_active <= ctrl[RCC_BIT_MRS];
            o_flash_regulator_sleep_active <= ctrl[RCC_BIT_FRS];
        end
    end

    // Reset cause flags
    AST_PIN_SET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_pin_reset_evt |=> ctrl[RCC_BIT_PIN])
        else $error("pin reset flag not set");
    AST_PIN_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!ctrl[RCC_BIT_PIN] && !i_pin_reset_evt && !(wr_ctrl && i_wdata[RCC_BIT_PIN])) |=> !ctrl[RCC_BIT_PIN])
        else $error("pin reset flag set without cause");
    AST_SOFT_SET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_soft_reset_evt |=> ctrl[RCC_BIT_SFT])
        else $error("soft reset flag not set");
    AST_SOFT_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!ctrl[RCC_BIT_SFT] && !i_soft_reset_evt && !(wr_ctrl && i_wdata[RCC_BIT_SFT])) |=> !ctrl[RCC_BIT_SFT])
        else $error("soft reset flag set without cause");
    AST_EVENT_STATUS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (evt != RCC_EV_ZERO) |=> ((irq_stat & $past(evt)) == $past(evt)))
        else $error("event status bit not set");

    // Fuse overrides and enables
    AST_WATCHDOG_SOFT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!i_fuse_watchdog_enable && wr_ctrl) ##1 !i_fuse_watchdog_enable
        |=> (o_watchdog_on == $past(i_wdata[RCC_BIT_WDE], 2)))
        else $error("watchdog does not follow soft enable");
    AST_WATCHDOG_FOLLOW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_fuse_watchdog_enable |=> (o_watchdog_on == $past(ctrl[RCC_BIT_WDE])))
        else $error("watchdog does not track soft enable");
    AST_WATCHDOG_FUSE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_fuse_watchdog_enable |=> o_watchdog_on)
        else $error("watchdog off with fuse enable");
    AST_BROWNOUT_FUSE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_fuse_brownout_enable |=> !o_brownout_on)
        else $error("brownout on with fuse disabled");
    AST_BROWNOUT_SOFT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_fuse_brownout_enable |=> (o_brownout_on == $past(ctrl[RCC_BIT_SBO])))
        else $error("brownout does not track soft enable");

    // Register access
    AST_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (wr_ctrl && !i_pin_reset_evt) |=> (ctrl[RCC_BIT_PIN] == $past(i_wdata[RCC_BIT_PIN])))
        else $error("flag write not stored");
    AST_SOFT_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (wr_ctrl && !i_soft_reset_evt) |=> (ctrl[RCC_BIT_SFT] == $past(i_wdata[RCC_BIT_SFT])))
        else $error("soft flag write not stored");
    AST_CTRL_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && i_addr == RCC_ADDR_CTRL) |=> (o_rdata == $past(ctrl)))
        else $error("control read does not return stored value");
    AST_MAIN_REG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_ctrl |=> ##1 (o_main_regulator_sleep_active == $past(i_wdata[RCC_BIT_MRS], 2)))
        else $error("main regulator select mismatch");
    AST_FLASH_REG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_ctrl |=> ##1 (o_flash_regulator_sleep_active == $past(i_wdata[RCC_BIT_FRS], 2)))
        else $error("flash regulator select mismatch");
    AST_UNIMP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && i_addr == RCC_ADDR_CTRL) |=> ((o_rdata & ~RCC_CTRL_MASK) == RCC_ZERO16))
        else $error("unimplemented bit reads one");

    // Values right after reset
    AST_RESET_VAL: assert property (@(posedge i_clk_sys)
        $fell(i_rst) |-> (ctrl == RCC_CTRL_RST))
        else $error("reset value wrong");
    AST_RESET_OUTS: assert property (@(posedge i_clk_sys)
        $fell(i_rst) |-> (!o_main_regulator_sleep_active && !o_flash_regulator_sleep_active && !o_irq))
        else $error("outputs not cleared by reset");

    // Scenarios worth seeing
    COV_PIN: cover property (@(posedge i_clk_sys) disable iff (i_rst) i_pin_reset_evt ##1 o_irq);
    COV_WR: cover property (@(posedge i_clk_sys) disable iff (i_rst) wr_ctrl ##1 i_rd);
    COV_CLR: cover property (@(posedge i_clk_sys) disable iff (i_rst) (wr_clr && |evt));
    COV_FUSE_OVERRIDE: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_fuse_watchdog_enable && wr_ctrl && !i_wdata[RCC_BIT_WDE]));
    COV_SET_WINS: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        (wr_ctrl && i_soft_reset_evt && !i_wdata[RCC_BIT_SFT]));
endmodule : rcc_regs

// ===== rcc_regs_bench.sv
// Testbench: register access, fuse overrides and event interrupts of the reset cause block
`timescale 1ns/1ns
module rcc_regs_bench
    import rcc_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [2:0] evt = 3'h0;
    logic fw = 1'b0;
    logic fb = 1'b1;
    logic [15:0] o_rdata;
    logic o_wd, o_bo, o_mr, o_fr, o_irq;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2 i_clk_sys = ~i_clk_sys;
    rcc_regs u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_reset_evt(evt[0]), .i_soft_reset_evt(evt[1]),
        .i_cfg_mismatch_evt(evt[2]), .i_fuse_watchdog_enable(fw), .i_fuse_brownout_enable(fb),
        .o_watchdog_on(o_wd), .o_brownout_on(o_bo), .o_main_regulator_sleep_active(o_mr),
        .o_flash_regulator_sleep_active(o_fr), .o_irq(o_irq));
    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string name);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_clk_sys);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e, "rdata");
    endtask : rd
    task automatic step();
        @(posedge i_clk_sys);
        #1;
    endtask : step
    task automatic pulse(input int k);
        @(posedge i_clk_sys);
        evt <= 3'(1 << k);
        @(posedge i_clk_sys);
        evt <= 3'h0;
        step();
    endtask : pulse
    task automatic test_fields();
        rd(RCC_ADDR_CTRL, RCC_CTRL_RST);
        chk(o_wd, 1'b0, "watchdog");
        wr(RCC_ADDR_CTRL, 16'hffff);
        step();
        chk(o_mr, 1'b1, "main");
        chk(o_fr, 1'b1, "flash");
        chk(o_wd, 1'b1, "watchdog");
        chk(o_bo, 1'b1, "brownout");
        rd(RCC_ADDR_CTRL, 16'h2be3);
        wr(RCC_ADDR_CTRL, 16'h0000);
        step();
        chk(o_wd, 1'b0, "watchdog");
        chk(o_mr, 1'b0, "main");
        chk(o_fr, 1'b0, "flash");
        chk(o_bo, 1'b0, "brownout");
        rd(RCC_ADDR_CTRL, 16'h0000);
        wr(4'h7, 16'hffff);
        rd(4'h7, 16'h0000);
        rd(RCC_ADDR_IRQ_CLR, 16'h0000);
        rd(RCC_ADDR_CTRL, 16'h0000);
        @(posedge i_clk_sys);
        fw <= 1'b1;
        fb <= 1'b0;
        wr(RCC_ADDR_CTRL, 16'h2000);
        step();
        chk(o_wd, 1'b1, "watchdog");
        chk(o_bo, 1'b0, "brownout");
        @(posedge i_clk_sys);
        fw <= 1'b0;
        fb <= 1'b1;
    endtask : test_fields
    task automatic test_event(input int k, input logic [15:0] fbit);
        wr(RCC_ADDR_CTRL, 16'h0000);
        wr(RCC_ADDR_IRQ_EN, 16'(1 << k));
        pulse(k);
        chk(o_irq, 1'b1, "irq");
        rd(RCC_ADDR_CTRL, fbit);
        rd(RCC_ADDR_IRQ_STAT, 16'(1 << k));
        wr(RCC_ADDR_IRQ_CLR, 16'(1 << k));
        step();
        chk(o_irq, 1'b0, "irq");
        rd(RCC_ADDR_CTRL, fbit);
        wr(RCC_ADDR_IRQ_EN, 16'h0000);
        pulse(k);
        step();
        chk(o_irq, 1'b0, "irq");
        rd(RCC_ADDR_IRQ_STAT, 16'(1 << k));
        wr(RCC_ADDR_IRQ_CLR, 16'h0007);
    endtask : test_event
    // Event and software write or clear in the same cycle: the event wins
    task automatic test_collide();
        @(posedge i_clk_sys);
        i_addr <= RCC_ADDR_CTRL;
        i_wdata <= 16'h0000;
        i_wr <= 1'b1;
        evt[1] <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        evt[1] <= 1'b0;
        rd(RCC_ADDR_CTRL, 16'h0040);
        @(posedge i_clk_sys);
        i_addr <= RCC_ADDR_IRQ_CLR;
        i_wdata <= 16'h0002;
        i_wr <= 1'b1;
        evt[1] <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        evt[1] <= 1'b0;
        rd(RCC_ADDR_IRQ_STAT, 16'h0002);
        wr(RCC_ADDR_IRQ_CLR, 16'h0002);
        rd(RCC_ADDR_IRQ_STAT, 16'h0000);
        wr(RCC_ADDR_IRQ_STAT, 16'h0007);
        rd(RCC_ADDR_IRQ_STAT, 16'h0000);
        wr(RCC_ADDR_CTRL, 16'h0000);
    endtask : test_collide
    // Reset in mid-run with every implemented bit set
    task automatic test_reset();
        wr(RCC_ADDR_CTRL, 16'h2be3);
        wr(RCC_ADDR_IRQ_EN, 16'h0007);
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(RCC_ADDR_CTRL, RCC_CTRL_RST);
        rd(RCC_ADDR_IRQ_EN, 16'h0000);
        chk(o_mr, 1'b0, "main");
        chk(o_fr, 1'b0, "flash");
        chk(o_wd, 1'b0, "watchdog");
        chk(o_bo, 1'b0, "brownout");
    endtask : test_reset
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        test_fields();
        test_event(0, 16'h0080);
        test_event(1, 16'h0040);
        test_event(2, 16'h0200);
        test_collide();
        test_reset();
        print_verdict();
    end
endmodule : rcc_regs_bench
